// ---- dpm_core.sv ----
// Dual-port 18 Kb block memory with per-port organization, write mode,
// output pipeline, split into two 9 Kb halves, and a small register port.
// Assumes both memory ports and the register port share mclk_in.
//
// How it works
// RULE1: 18 Kb array shared by two independent ports
// RULE2: Port inputs captured in input registers first
// RULE3: Read output held until next enabled operation
// RULE4: Optional output register adds one cycle
// RULE5: Write shows old, new, or unchanged output
// RULE6: Six depth-by-width organizations per port
// RULE7: Wide organizations store one parity bit per byte
// RULE8: Ports may use different organizations together
// RULE9: Split mode gives two independent 9 Kb halves; with simple dual-port, both ports share the low half
// RULE10: Half-size 256x36 only in simple dual-port
// RULE11: Same-address writes from both ports are undefined
`timescale 1ns/1ps
module dpm_core
  import dpm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Memory port A
  input wire dpm_pkg::dpm_req_s port_a_in,
  output dpm_pkg::dpm_word_s port_a_rdata_out,
  // Memory port B
  input wire dpm_pkg::dpm_req_s port_b_in,
  output dpm_pkg::dpm_word_s port_b_rdata_out,
  // Register port
  input wire logic [dpm_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);
  import dpm_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Address bits that select a lane inside a 36-bit word
  function automatic logic [2:0] width_shift(input logic [2:0] wid);
    logic [2:0] s;
    s = 3'h0;
    unique case (wid)
      WID_X1: s = 3'h5;
      WID_X2: s = 3'h4;
      WID_X4: s = 3'h3;
      WID_X9: s = 3'h2;
      WID_X18: s = 3'h1;
      default: s = 3'h0;
    endcase
    return s;
  endfunction : width_shift

  // Parity bits carried by one element
  function automatic logic [2:0] par_width(input logic [2:0] wid);
    logic [2:0] pw;
    pw = 3'h0;
    unique case (wid)
      WID_X9: pw = 3'h1;
      WID_X18: pw = 3'h2;
      WID_X36: pw = 3'h4;
      default: pw = 3'h0;
    endcase
    return pw;
  endfunction : par_width

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpm_word_s mem_r [DEPTH];
  dpm_word_s mem_nxt [DEPTH];
  dpm_req_s req_r [NPORT];
  dpm_req_s req_nxt [NPORT];
  dpm_word_s latch_r [NPORT];
  dpm_word_s latch_nxt [NPORT];
  dpm_word_s out_r [NPORT];
  dpm_word_s out_nxt [NPORT];
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Per-port decode results
  dpm_req_s req_in [NPORT];
  logic [2:0] wid [NPORT];
  logic [1:0] wmode [NPORT];
  logic pipe [NPORT];
  logic ok [NPORT];
  logic wr_go [NPORT];
  logic [IDX_W-1:0] word [NPORT];
  logic [LANE_W-1:0] ofs [NPORT];
  logic [1:0] pofs [NPORT];
  logic [DATA_W-1:0] dmask [NPORT];
  logic [PAR_W-1:0] pmask [NPORT];
  dpm_word_s rd_el [NPORT];
  dpm_word_s wr_el [NPORT];
  logic split;
  logic sdp;
  logic coll;
  logic refuse;

  // Port requests and global mode bits
  assign req_in[0] = port_a_in;
  assign req_in[1] = port_b_in;
  assign split = cfg_r[CFG_SPLIT_POS];
  assign sdp = cfg_r[CFG_SDP_POS];

  // ----------------------------------------------------------------
  // Port decode: organization, word index, lane masks
  // ----------------------------------------------------------------

  // Address mapping per port onto the shared bits
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      logic [2:0] s;
      logic [5:0] dw;
      logic [2:0] pw;
      logic [ADDR_W-1:0] lane;
      logic [ADDR_W-1:0] widx;

      // Element size of the selected organization
      s = width_shift(cfg_r[CFG_A_WID_POS + p*CFG_PORT_STRIDE +: 3]); // [RULE6]
      dw = 6'(6'd32 >> s);
      pw = par_width(cfg_r[CFG_A_WID_POS + p*CFG_PORT_STRIDE +: 3]); // [RULE7]
      // Word index and lane inside the word
      widx = req_r[p].addr >> s;
      lane = req_r[p].addr & ((14'h0001 << s) - 14'h0001);
      // Per-port settings from the config register
      wid[p] = cfg_r[CFG_A_WID_POS + p*CFG_PORT_STRIDE +: 3]; // [RULE8]
      wmode[p] = cfg_r[CFG_A_WM_POS + p*CFG_PORT_STRIDE +: 2];
      pipe[p] = cfg_r[CFG_A_PIPE_POS + p*CFG_PORT_STRIDE];
      // Bit offsets and masks of the element
      ofs[p] = LANE_W'(lane * 14'(dw));
      pofs[p] = 2'(lane * 14'(pw));
      dmask[p] = DATA_W'(((33'h0_0000_0001 << dw) - 33'h0_0000_0001) << ofs[p]);
      pmask[p] = PAR_W'(((5'h01 << pw) - 5'h01) << pofs[p]);
      if (split)
      begin
        // Port A owns the low half, port B the high half; in simple dual-port both use the low half
        word[p] = {(sdp ? 1'b0 : 1'(p)), widx[HALF_IDX_W-1:0]}; // [RULE9]
      end
      else
      begin
        word[p] = widx[IDX_W-1:0]; // [RULE1]
      end
      // Refused: bad code, half-size x36 outside simple dual-port,
      // or the wrong direction for a port in simple dual-port
      ok[p] = (wid[p] <= WID_X36)
        && !(split && (wid[p] == WID_X36) && !sdp) // [RULE10]
        && !(sdp && (p == 0) && !req_r[p].we)
        && !(sdp && (p == 1) && req_r[p].we);
      wr_go[p] = ok[p] && req_r[p].en && req_r[p].we;
      // Element read out, write data trimmed to it
      rd_el[p].data = (mem_r[word[p]].data & dmask[p]) >> ofs[p];
      rd_el[p].par = (mem_r[word[p]].par & pmask[p]) >> pofs[p];
      wr_el[p].data = req_r[p].wdata.data & (dmask[p] >> ofs[p]);
      wr_el[p].par = req_r[p].wdata.par & (pmask[p] >> pofs[p]);
    end
  end

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------

  // Capture every port input at the clock edge
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      req_nxt[p] = req_in[p]; // [RULE2]
    end
  end

  // Input registers clear to idle on reset
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        req_r[p] <= REQ_IDLE;
      end
    end
    else
    begin
      req_r <= req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Shared array
  // ----------------------------------------------------------------

  // Masked writes; port B lands last on an overlap
  always_comb
  begin
    mem_nxt = mem_r;
    for (int p = 0; p < NPORT; p++)
    begin
      // Merge the element into its word
      if (wr_go[p])
      begin
        mem_nxt[word[p]].data = (mem_nxt[word[p]].data & ~dmask[p])
          | ((req_r[p].wdata.data << ofs[p]) & dmask[p]);
        mem_nxt[word[p]].par = (mem_nxt[word[p]].par & ~pmask[p])
          | ((req_r[p].wdata.par << pofs[p]) & pmask[p]); // [RULE7]
      end
    end

    // Overlapping writes in one cycle flag a collision; port B's data is kept
    coll = wr_go[0] && wr_go[1] && (word[0] == word[1])
      && (((dmask[0] & dmask[1]) != '0) || ((pmask[0] & pmask[1]) != '0)); // [RULE11]
    // Any enabled request that the decode refuses
    refuse = (req_r[0].en && !ok[0]) || (req_r[1].en && !ok[1]);
  end

  // Storage has no reset
  always_ff @(posedge mclk_in)
  begin
    mem_r <= mem_nxt;
  end

  // ----------------------------------------------------------------
  // Output latch and pipeline
  // ----------------------------------------------------------------

  // Latch follows the write mode; otherwise holds
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      latch_nxt[p] = latch_r[p]; // [RULE3]
      if (ok[p] && req_r[p].en)
      begin
        if (!req_r[p].we)
        begin
          latch_nxt[p] = rd_el[p];
        end
        else if (wmode[p] == WM_READ_FIRST)
        begin
          latch_nxt[p] = rd_el[p]; // [RULE5]
        end
        else if (wmode[p] == WM_WRITE_FIRST)
        begin
          latch_nxt[p] = wr_el[p]; // [RULE5]
        end
      end

      // Pipeline takes the latch one cycle late
      out_nxt[p] = pipe[p] ? latch_r[p] : latch_nxt[p]; // [RULE4]
    end
  end

  // Output latch and pipeline registers
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        latch_r[p] <= WORD_ZERO;
        out_r[p] <= WORD_ZERO;
      end
    end
    else
    begin
      latch_r <= latch_nxt;
      out_r <= out_nxt;
    end
  end

  // Read data straight from the output registers
  assign port_a_rdata_out = out_r[0];
  assign port_b_rdata_out = out_r[1];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------

  // Config write, sticky status with set over clear, read data
  always_comb
  begin
    logic [1:0] clr;
    clr = 2'h0;
    cfg_nxt = cfg_r;
    rdata_nxt = 32'h0000_0000;

    // Config write keeps only the defined bits
    if (reg_wr_in && (reg_addr_in == CFG_OFF))
    begin
      cfg_nxt = reg_wdata_in & CFG_MASK;
    end
    // Status bits clear where ones are written
    if (reg_wr_in && (reg_addr_in == STAT_OFF))
    begin
      clr = reg_wdata_in[1:0];
    end
    stat_nxt = stat_r & ~clr;
    stat_nxt[STAT_COLL_POS] = stat_nxt[STAT_COLL_POS] | coll;
    stat_nxt[STAT_REFUSE_POS] = stat_nxt[STAT_REFUSE_POS] | refuse;
    // Read data stands for one cycle only
    if (reg_rd_in)
    begin
      if (reg_addr_in == CFG_OFF)
      begin
        rdata_nxt = cfg_r;
      end
      else if (reg_addr_in == STAT_OFF)
      begin
        rdata_nxt = {30'h0000_0000, stat_r};
      end
    end
  end

  // Register port state
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cfg_r <= CFG_RST;
      stat_r <= STAT_RST;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      stat_r <= stat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Register read data from its flip-flop
  assign reg_rdata_out = rdata_r;

endmodule : dpm_core

// ---- dpm_pkg.sv ----
// Constants, field layouts and carrier types of the dual-port block memory.
// Assumes one system clock for both memory ports and the register port.
package dpm_pkg;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int DEPTH = 512;
  localparam int IDX_W = 9;
  localparam int HALF_IDX_W = 8;
  localparam int LANE_W = 5;
  localparam int NPORT = 2;

  // ----------------------------------------------------------------
  // Organization codes (port width)
  // ----------------------------------------------------------------
  localparam logic [2:0] WID_X1 = 3'h0;
  localparam logic [2:0] WID_X2 = 3'h1;
  localparam logic [2:0] WID_X4 = 3'h2;
  localparam logic [2:0] WID_X9 = 3'h3;
  localparam logic [2:0] WID_X18 = 3'h4;
  localparam logic [2:0] WID_X36 = 3'h5;

  // ----------------------------------------------------------------
  // Output behaviour during a write
  // ----------------------------------------------------------------
  localparam logic [1:0] WM_READ_FIRST = 2'h0;
  localparam logic [1:0] WM_WRITE_FIRST = 2'h1;
  localparam logic [1:0] WM_NO_CHANGE = 2'h2;

  // ----------------------------------------------------------------
  // Register port map and fields
  // ----------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam logic [3:0] CFG_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam int CFG_A_WID_POS = 0;
  localparam int CFG_A_WM_POS = 3;
  localparam int CFG_A_PIPE_POS = 5;
  localparam int CFG_PORT_STRIDE = 8;
  localparam int CFG_SPLIT_POS = 16;
  localparam int CFG_SDP_POS = 17;
  localparam logic [31:0] CFG_MASK = 32'h0003_3F3F;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int STAT_COLL_POS = 0;
  localparam int STAT_REFUSE_POS = 1;
  localparam logic [1:0] STAT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PAR_W-1:0] par;
    logic [DATA_W-1:0] data;
  } dpm_word_s;

  typedef struct packed {
    logic en;
    logic we;
    logic [ADDR_W-1:0] addr;
    dpm_word_s wdata;
  } dpm_req_s;

  localparam dpm_req_s REQ_IDLE = '0;
  localparam dpm_word_s WORD_ZERO = '0;

endpackage : dpm_pkg

// ---- dpm_props.sv ----
// Port timing checker of the dual-port block memory.
// Assumes it is bound to dpm_core, one clock for everything.
`timescale 1ns/1ps
module dpm_props
  import dpm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Memory ports
  input wire dpm_pkg::dpm_req_s port_a_in,
  input wire dpm_pkg::dpm_word_s port_a_rdata_out,
  input wire dpm_pkg::dpm_req_s port_b_in,
  input wire dpm_pkg::dpm_word_s port_b_rdata_out,
  // Register port
  input wire logic [dpm_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out
);
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [2:0] idl_r;
  logic [2:0] idl_nxt;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // -------------------------------
  // Shadow config and idle count
  // -------------------------------
  always_comb
  begin
    cfg_nxt = (reg_wr_in && reg_addr_in == CFG_OFF) ? reg_wdata_in & CFG_MASK : cfg_r;
    idl_nxt = (port_b_in.en || reg_wr_in) ? 3'h0 : idl_r + {2'h0, idl_r != 3'h7};
  end
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cfg_r <= CFG_RST;
      idl_r <= 3'h0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      idl_r <= idl_nxt;
    end
  end
  // -------------------------------
  // Assertions
  // -------------------------------
  chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
    else $error("register data outside read");
  chk_cfg_readback: assert property (reg_rd_in && reg_addr_in == CFG_OFF
    |=> reg_rdata_out == cfg_r)
    else $error("config readback");
  chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in > STAT_OFF |=> reg_rdata_out == '0)
    else $error("unmapped read not zero");
  chk_a_idle_hold: assert property ((!port_a_in.en && !reg_wr_in) [*3]
    |=> $stable(port_a_rdata_out))
    else $error("port A output moved while idle");
  chk_b_idle_hold: assert property (idl_r >= 3'h3 |-> $stable(port_b_rdata_out))
    else $error("port B output moved while idle");
  chk_a_nochange: assert property (port_a_in.en && port_a_in.we && cfg_r[4] && !cfg_r[5]
    |=> ##1 $stable(port_a_rdata_out)) else $error("no-change write moved output");
  chk_a_write_first: assert property (port_a_in.en && port_a_in.we && cfg_r[5:0] == 6'h0D
    && cfg_r[17:16] == 2'h0 |=> ##1 port_a_rdata_out == $past(port_a_in.wdata, 2))
    else $error("write-first output wrong");
  chk_b_pipe_delay: assert property (!port_b_in.en ##1 (port_b_in.en && cfg_r[13])
    |=> ##1 $stable(port_b_rdata_out)) else $error("pipelined output too early");
  cov_wfirst: cover property (port_a_in.en && port_a_in.we && cfg_r[5:0] == 6'h0D);
  cov_split: cover property (port_b_in.en && cfg_r[17:16] == 2'h1);
  cov_sdp: cover property (port_b_in.en && cfg_r[17:16] == 2'h3);
endmodule : dpm_props
bind dpm_core dpm_props dpm_props_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .port_a_in(port_a_in), .port_a_rdata_out(port_a_rdata_out), .port_b_in(port_b_in),
  .port_b_rdata_out(port_b_rdata_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));

// ---- dpm_user.sv ----
// User logic model driving both memory ports.
// Assumes drive is called once per cycle by the bench.
`timescale 1ns/1ps
module dpm_user
  import dpm_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Requests toward the memory
  output dpm_pkg::dpm_req_s port_a_out,
  output dpm_pkg::dpm_req_s port_b_out
);
  initial port_a_out = REQ_IDLE;
  initial port_b_out = REQ_IDLE;
  // One cycle; the idle port inverts its stale lines
  task automatic drive(input int p, input dpm_req_s r);
    dpm_req_s ia;
    dpm_req_s ib;
    @(posedge mclk_in);
    ia = ~port_a_out;
    ia.en = 1'b0;
    ib = ~port_b_out;
    ib.en = 1'b0;
    port_a_out <= (p == 0) ? r : ia;
    port_b_out <= (p == 1) ? r : ib; // one port per cycle
  endtask : drive
endmodule : dpm_user

// ---- test_dpm_core.sv ----
// Self-checking bench of the dual-port block memory.
// Assumes dpm_core, dpm_user and dpm_props compiled alongside.
`timescale 1ns/1ps
module test_dpm_core;
  import dpm_pkg::*;
  logic mclk_in;
  logic arst_n_in;
  logic [REG_AW-1:0] raddr;
  logic [31:0] rwdata;
  logic rwr;
  logic rrd;
  logic [31:0] rrdata;
  dpm_req_s ra;
  dpm_req_s rb;
  dpm_word_s qa;
  dpm_word_s qb;
  dpm_word_s mem [DEPTH];
  dpm_word_s last [NPORT];
  logic [31:0] seed;
  logic [31:0] cfg;
  logic [31:0] tbl [5] = '{32'h0000_250D, 32'h0001_1414, 32'h0003_0505, 32'h0000_0300,
    32'h0002_3214};
  int error_cnt;
  int checked;
  dpm_core dpm_core_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .port_a_in(ra),
    .port_a_rdata_out(qa), .port_b_in(rb), .port_b_rdata_out(qb), .reg_addr_in(raddr),
    .reg_wdata_in(rwdata), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rrdata));
  dpm_user dpm_user_inst (.mclk_in(mclk_in), .port_a_out(ra), .port_b_out(rb));
  // Clock
  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    error_cnt++;
    close_out();
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    raddr <= a;
    rwdata <= d;
    rwr <= 1'b1;
    @(posedge mclk_in);
    rwr <= 1'b0;
  endtask : rw
  task automatic rr(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    raddr <= a;
    rrd <= 1'b1;
    @(posedge mclk_in);
    rrd <= 1'b0;
    #1;
    chk("register", {4'h0, rrdata}, {4'h0, exp});
  endtask : rr
  // Storage word a port address lands in
  function automatic int widx(input int p, input logic [13:0] a);
    int w;
    w = int'(a) >> (5 - int'(cfg[p*8 +: 3]));
    return cfg[16] ? ((cfg[17] ? 0 : p) * 256 + w % 256) : w % 512;
  endfunction : widx
  // Old element at a port address, optionally overwritten
  function automatic dpm_word_s acc(input int p, input logic [13:0] a, input bit wr,
    input dpm_word_s v);
    int s;
    int w;
    int pw;
    int ln;
    logic [63:0] dm;
    logic [7:0] pm;
    dpm_word_s m;
    dpm_word_s r;
    s = 5 - int'(cfg[p*8 +: 3]);
    w = 32 >> s;
    pw = (s < 3) ? (4 >> s) : 0;
    ln = int'(a) % (1 << s);
    dm = ((64'h1 << w) - 64'h1) << (ln * w);
    pm = 8'(((9'h001 << pw) - 9'h001) << (ln * pw));
    m = mem[widx(p, a)];
    r.data = 32'(({32'h0, m.data} & dm) >> (ln * w));
    r.par = 4'(({4'h0, m.par} & pm) >> (ln * pw));
    m.data = 32'(({32'h0, m.data} & ~dm) | (({32'h0, v.data} << (ln * w)) & dm));
    m.par = 4'(({4'h0, m.par} & ~pm) | (({4'h0, v.par} << (ln * pw)) & pm));
    if (wr)
      mem[widx(p, a)] = m;
    return r;
  endfunction : acc
  function automatic bit refused(input int p, input bit we);
    logic [2:0] c;
    c = cfg[p*8 +: 3];
    return c > 3'h5 || (cfg[16] && c == 3'h5 && !cfg[17]) || (cfg[17] && (p == 0) != we);
  endfunction : refused
  task automatic op(input int p, input bit we, input logic [13:0] a, input dpm_word_s v);
    dpm_word_s e;
    logic [1:0] m;
    m = cfg[p*8+3 +: 2];
    e = last[p];
    if (!refused(p, we))
    begin
      e = acc(p, a, we, v);
      if (we && m == WM_WRITE_FIRST)
        e = acc(p, a, 1'b0, v);
      else if (we && m[1])
        e = last[p];
    end
    dpm_user_inst.drive(p, dpm_req_s'{1'b1, we, a, v});
    dpm_user_inst.drive(2, REQ_IDLE);
    @(posedge mclk_in);
    #1;
    if (cfg[p*8+5])
    begin
      chk("early data", p ? qb : qa, last[p]);
      @(posedge mclk_in);
      #1;
    end
    chk("read data", p ? qb : qa, e);
    last[p] = e;
  endtask : op
  task automatic set(input logic [31:0] c);
    rw(CFG_OFF, c);
    cfg = c & CFG_MASK;
    rr(CFG_OFF, cfg);
  endtask : set
  // Main sequence
  initial
  begin
    arst_n_in = 1'b0;
    raddr = '0;
    rwdata = '0;
    rwr = 1'b0;
    rrd = 1'b0;
    seed = 32'h0000_0036;
    cfg = '0;
    error_cnt = 0;
    checked = 0;
    last = '{WORD_ZERO, WORD_ZERO};
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rr(STAT_OFF, 32'h0000_0000);
    rw(4'h8, 32'hFFFF_FFFF);
    rr(4'h8, 32'h0000_0000);
    rr(CFG_OFF, CFG_RST);
    set(32'hFFFF_FFFF);
    op(0, 1'b1, 14'h0000, WORD_ZERO);
    rr(STAT_OFF, 32'h0000_0002);
    rw(STAT_OFF, 32'h0000_0002);
    rr(STAT_OFF, 32'h0000_0000);
    set(32'h0000_000D);
    for (int i = 0; i < DEPTH; i++)
      op(0, 1'b1, 14'(i), dpm_word_s'(36'({rnd(), rnd()})));
    for (int j = 0; j < 30; j++)
    begin
      set(j < 5 ? tbl[j] : rnd());
      repeat (12) op(int'(rnd() % 2), rnd() % 2, 14'(rnd()), dpm_word_s'(36'({rnd(), rnd()})));
    end
    close_out();
  end
endmodule : test_dpm_core
